/* File: pkg/dbpc_map.svh */
/*
  Constants for the bank-close control block: command codes, field positions on
  the six command/address lines, burst settings and default timing counts.
  Assumes one 100 MHz clock; counts are whole clock cycles.
*/
`ifndef DBPC_MAP_SVH
`define DBPC_MAP_SVH

// Command/address field positions
`define DBPC_ALL_BANK_BIT   5
`define DBPC_AUTO_CLOSE_BIT 5
`define DBPC_BANK_MSB      2
`define DBPC_CMD_MSB       4

// First-cycle command codes on CA[4:0] (CA5 carries the flag)
`define DBPC_CODE_ACT      5'h01
`define DBPC_CODE_PRE      5'h10
`define DBPC_CODE_WR       5'h04
`define DBPC_CODE_MWR      5'h0C
`define DBPC_CODE_RD       5'h02

// Burst lengths and the extra delay that length 32 adds to a read close
`define DBPC_BL16          6'h10
`define DBPC_BL32          6'h20
`define DBPC_BL32_EXTRA    8'h08

// Default timing counts in clock cycles
`define DBPC_RTP_CYC       8'h08
`define DBPC_WR_CYC        8'h12
`define DBPC_WL_CYC        8'h08
`define DBPC_RAS_CYC       8'h2A
`define DBPC_RPPB_CYC      8'h12
`define DBPC_RPAB_CYC      8'h15

`endif

/* File: pkg/dbpc_pkg.sv */
/*
  Types for the bank-close control block.
  Assumes dbpc_map.svh supplies the numeric constants.
*/
package dbpc_pkg;

  // Decoded command kinds
  typedef enum logic [2:0] {
    DBPC_CMD_NONE,
    DBPC_CMD_ACT,
    DBPC_CMD_PRE,
    DBPC_CMD_RD,
    DBPC_CMD_WR
  } dbpc_cmd_t;

  // Per-bank state
  typedef enum logic [1:0] {
    DBPC_IDLE,
    DBPC_ACTIVE,
    DBPC_CLOSE_PEND,
    DBPC_CLOSING
  } dbpc_bank_t;

endpackage : dbpc_pkg

/* File: verilog/dbpc_bank.sv */
/*
  One bank's open/close tracker: counts row-active time, holds a pending
  auto-close until its delay and the row-active time are both met, then counts
  the precharge time back to idle.
  Assumes the parent decodes commands and presents one-cycle strobes.
*/
`timescale 1ns/1ns
`include "dbpc_map.svh"
module dbpc_bank
  import dbpc_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       srst,
  input  wire logic       act,
  input  wire logic       close_now,
  input  wire logic       close_all,
  input  wire logic       auto_arm,
  input  wire logic [7:0] auto_delay,
  input  wire logic [7:0] ras_cyc,
  input  wire logic [7:0] rppb_cyc,
  input  wire logic [7:0] rpab_cyc,
  output dbpc_bank_t      state,
  output logic            close_start
);

  logic [7:0] ras_cnt;
  logic [7:0] dly_cnt;
  logic [7:0] rp_cnt;
  logic       ras_met;
  logic       start;

  assign ras_met = (ras_cnt >= ras_cyc);
  // Internal close fires once the auto delay ran out and row-active time is met
  assign start   = (state == DBPC_CLOSE_PEND) && (dly_cnt == 8'h00) && ras_met;

  // Row-active time counter; only an activation that opens the bank restarts it,
  // so an ignored activation of an open bank cannot stretch the lockout
  always_ff @(posedge clk) begin
    if (srst || (act && state == DBPC_IDLE)) begin
      ras_cnt <= 8'h00;
    end else if (!ras_met) begin
      ras_cnt <= ras_cnt + 8'h01;
    end
  end

  // Auto-close delay counter
  always_ff @(posedge clk) begin
    if (srst) begin
      dly_cnt <= 8'h00;
    end else if (auto_arm && state == DBPC_ACTIVE) begin
      dly_cnt <= auto_delay;
    end else if (dly_cnt != 8'h00) begin
      dly_cnt <= dly_cnt - 8'h01;
    end
  end

  // Bank state machine
  always_ff @(posedge clk) begin
    if (srst) begin
      state       <= DBPC_IDLE;
      rp_cnt      <= 8'h00;
      close_start <= 1'b0;
    end else begin
      close_start <= 1'b0;
      case (state)
        DBPC_IDLE: begin
          // Close requests to an idle bank leave it untouched
          if (act) begin
            state <= DBPC_ACTIVE;
          end
        end
        DBPC_ACTIVE: begin
          if (close_now) begin
            state       <= DBPC_CLOSING;
            rp_cnt      <= close_all ? rpab_cyc : rppb_cyc;
            close_start <= 1'b1;
          end else if (auto_arm) begin
            state <= DBPC_CLOSE_PEND;
          end
        end
        DBPC_CLOSE_PEND: begin
          if (close_now || start) begin
            state       <= DBPC_CLOSING;
            rp_cnt      <= (close_now && close_all) ? rpab_cyc : rppb_cyc;
            close_start <= 1'b1;
          end
        end
        DBPC_CLOSING: begin
          if (rp_cnt <= 8'h01) begin
            state <= DBPC_IDLE;
          end else begin
            rp_cnt <= rp_cnt - 8'h01;
          end
        end
        default: state <= DBPC_IDLE;
      endcase
    end
  end

endmodule : dbpc_bank

/* File: verilog/dbpc_top.sv */
/*
  Bank-close control of a low-power DRAM die: decodes two-cycle commands on
  chip select and six command/address lines, closes one or all banks on an
  explicit close, and schedules auto-close after reads and writes.
  Assumes cs and ca are already in the clk domain (sampled at the command clock).
*/
`timescale 1ns/1ns
`include "dbpc_map.svh"
module dbpc_top
  import dbpc_pkg::*;
#(
  parameter int          NUM_BANKS = 8,
  parameter logic [7:0]  RTP_CYC   = `DBPC_RTP_CYC,
  parameter logic [7:0]  WR_CYC    = `DBPC_WR_CYC,
  parameter logic [7:0]  WL_CYC    = `DBPC_WL_CYC,
  parameter logic [7:0]  RAS_CYC   = `DBPC_RAS_CYC,
  parameter logic [7:0]  RPPB_CYC  = `DBPC_RPPB_CYC,
  parameter logic [7:0]  RPAB_CYC  = `DBPC_RPAB_CYC
)(
  input  wire logic                 clk,
  input  wire logic                 srst,
  input  wire logic                 cs,
  input  wire logic [5:0]           ca,
  input  wire logic                 burst_32,
  output logic [NUM_BANKS-1:0]      bank_open,
  output logic [NUM_BANKS-1:0]      bank_closing,
  output logic [NUM_BANKS-1:0]      close_event
);

  // Two-cycle command capture
  logic                 second;
  dbpc_cmd_t            cmd;
  logic                 flag;
  dbpc_cmd_t            first_cmd;
  logic                 all_bank_flag;
  logic                 auto_close_flag;
  logic [2:0]           bank_sel;
  logic                 cmd_valid;
  logic [NUM_BANKS-1:0] act_v;
  logic [NUM_BANKS-1:0] close_v;
  logic [NUM_BANKS-1:0] arm_v;
  logic [NUM_BANKS-1:0] start_v;
  dbpc_bank_t           st_v [NUM_BANKS];
  logic [7:0]           rd_delay;
  logic [7:0]           wr_delay;
  logic [7:0]           half_bl;

  // Decode the first-cycle code on CA[4:0]
  function automatic dbpc_cmd_t decode(input logic [4:0] code);
    if (code == `DBPC_CODE_ACT) begin
      decode = DBPC_CMD_ACT;
    end else if (code == `DBPC_CODE_PRE) begin
      decode = DBPC_CMD_PRE;
    end else if (code == `DBPC_CODE_RD) begin
      decode = DBPC_CMD_RD;
    end else if (code == `DBPC_CODE_WR || code == `DBPC_CODE_MWR) begin
      decode = DBPC_CMD_WR;
    end else begin
      decode = DBPC_CMD_NONE;
    end
  endfunction : decode

  assign cmd = decode(ca[`DBPC_CMD_MSB:0]);

  // First cycle latches kind and CA5; second cycle brings the bank bits
  always_ff @(posedge clk) begin
    if (srst) begin
      second    <= 1'b0;
      first_cmd <= DBPC_CMD_NONE;
      flag      <= 1'b0;
    end else if (!second && cs && cmd != DBPC_CMD_NONE) begin
      second    <= 1'b1;
      first_cmd <= cmd;
      flag      <= ca[`DBPC_ALL_BANK_BIT];
    end else begin
      second    <= 1'b0;
    end
  end

  assign cmd_valid       = second;
  assign bank_sel        = ca[`DBPC_BANK_MSB:0];
  assign all_bank_flag   = flag;
  assign auto_close_flag = flag;

  // Read close delay: the read-to-close count, eight more for length 32.
  // Measured from the second command cycle, so BL/2-8 offset is folded in.
  assign rd_delay = burst_32 ? (RTP_CYC + `DBPC_BL32_EXTRA) : RTP_CYC;
  assign half_bl  = burst_32 ? {2'b00, `DBPC_BL32} >> 1 : {2'b00, `DBPC_BL16} >> 1;
  // Write close: latency, half burst, one, then recovery from the group edge
  assign wr_delay = WL_CYC + half_bl + 8'h01 + WR_CYC;

  // Per-bank strobes from the completed command
  always_comb begin
    for (int i = 0; i < NUM_BANKS; i++) begin
      act_v[i]   = 1'b0;
      close_v[i] = 1'b0;
      arm_v[i]   = 1'b0;
      if (cmd_valid && (bank_sel == i[2:0] || (first_cmd == DBPC_CMD_PRE && all_bank_flag))) begin
        act_v[i]   = (first_cmd == DBPC_CMD_ACT) && (bank_sel == i[2:0]);
        close_v[i] = (first_cmd == DBPC_CMD_PRE);
        // Flag clear leaves the bank open after the burst
        arm_v[i]   = (first_cmd == DBPC_CMD_RD || first_cmd == DBPC_CMD_WR)
                     && auto_close_flag;
      end
    end
  end

  // One tracker per bank
  for (genvar g = 0; g < NUM_BANKS; g++) begin : g_bank
    dbpc_bank u_bank (
      .clk         (clk),
      .srst        (srst),
      .act         (act_v[g]),
      .close_now   (close_v[g]),
      .close_all   (all_bank_flag),
      .auto_arm    (arm_v[g]),
      .auto_delay  (first_cmd == DBPC_CMD_RD ? rd_delay : wr_delay),
      .ras_cyc     (RAS_CYC),
      .rppb_cyc    (RPPB_CYC),
      .rpab_cyc    (RPAB_CYC),
      .state       (st_v[g]),
      .close_start (start_v[g])
    );
  end

  // Registered status outputs
  always_ff @(posedge clk) begin
    if (srst) begin
      bank_open    <= '0;
      bank_closing <= '0;
      close_event  <= '0;
    end else begin
      for (int i = 0; i < NUM_BANKS; i++) begin
        bank_open[i]    <= (st_v[i] == DBPC_ACTIVE) || (st_v[i] == DBPC_CLOSE_PEND);
        bank_closing[i] <= (st_v[i] == DBPC_CLOSING);
      end
      close_event <= start_v;
    end
  end

endmodule : dbpc_top

/* File: tb/dbpc_chk.sv */
/* Port checker for dbpc_top: close decode, pulses and open/closing flags.
   Assumes a bind to dbpc_top and two-clock commands on cs and ca. */
`timescale 1ns/1ns
`include "dbpc_map.svh"
module dbpc_chk #(
  parameter int NUM_BANKS = 8
)(
  input wire logic                 clk,
  input wire logic                 srst,
  input wire logic                 cs,
  input wire logic [5:0]           ca,
  input wire logic                 burst_32,
  input wire logic [NUM_BANKS-1:0] bank_open,
  input wire logic [NUM_BANKS-1:0] bank_closing,
  input wire logic [NUM_BANKS-1:0] close_event
);
  logic       c2;
  logic [5:0] c1;
  logic [2:0] bk;
  wire        pre = c2 && c1[4:0] == `DBPC_CODE_PRE;
  // First cycle seen; the next cycle carries the bank
  always_ff @(posedge clk) begin
    c2 <= !srst && cs;
    c1 <= ca;
  end
  // Bank held until the next command, so later checks still know it
  always_ff @(posedge clk) begin
    if (c2) begin
      bk <= ca[2:0];
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  a_pre_one_bank: assert property (
    pre && !c1[5] && bank_open[ca[2:0]] |-> ##2 close_event[bk])
    else $error("single bank close missed");
  a_pre_all_banks: assert property (
    pre && c1[5] |-> ##2 close_event == $past(bank_open, 2))
    else $error("all bank close wrong");
  a_idle_close_ignored: assert property (
    pre && bank_open == '0 |=> (close_event == '0)[*2])
    else $error("idle close acted");
  a_event_one_cycle: assert property (
    close_event != '0 |=> (close_event & $past(close_event)) == '0)
    else $error("close pulse too long");
  a_open_drops: assert property ((close_event & bank_open) == '0)
    else $error("bank open while closing starts");
  a_closing_follows: assert property (
    close_event != '0 |=> (bank_closing & $past(close_event)) == $past(close_event))
    else $error("closing flag missing");
  a_close_was_open: assert property (
    close_event != '0 |-> (close_event & ~$past(bank_open)) == '0)
    else $error("idle bank closed");
  a_plain_read_open: assert property (
    c2 && c1 == {1'b0, `DBPC_CODE_RD} && bank_open[ca[2:0]]
    |=> (bank_open[bk] && !close_event[bk])[*8])
    else $error("plain read closed bank");
  a_act_opens: assert property (
    c2 && c1[4:0] == `DBPC_CODE_ACT && !bank_open[ca[2:0]] && !bank_closing[ca[2:0]]
    |-> ##2 bank_open[bk])
    else $error("activate did not open");
  cover property (pre && c1[5]);
  cover property (pre && bank_open == '0);
  cover property (close_event != '0 && !$past(pre, 2));
endmodule : dbpc_chk
bind dbpc_top dbpc_chk #(.NUM_BANKS(NUM_BANKS)) i_chk (
  .clk(clk), .srst(srst), .cs(cs), .ca(ca), .burst_32(burst_32),
  .bank_open(bank_open), .bank_closing(bank_closing), .close_event(close_event)
);

/* File: tb/dbpc_ctl_model.sv */
/* Memory controller model: sends two-clock commands on cs and ca.
   Assumes the bench calls send and spaces commands legally. */
`timescale 1ns/1ns
module dbpc_ctl_model (
  input  wire logic       clk,
  output logic            cs,
  output logic [5:0]      ca
);
  initial begin
    cs = 1'b0;
    ca = 6'h00;
  end
  // Kind and flag, then bank; released lines flip so stale values never look valid
  task automatic send(input logic [4:0] code, input logic flag, input logic [2:0] bank);
    @(posedge clk);
    #1 cs = 1'b1;
    ca = {flag, code};
    @(posedge clk);
    #1 cs = 1'b0;
    ca = {3'h0, bank};
    @(posedge clk);
    #1 ca = ~ca;
  endtask : send
endmodule : dbpc_ctl_model

/* File: tb/dbpc_top_tb_top.sv */
/* Bench for dbpc_top: single, all-bank, idle and auto closes.
   Assumes the controller model and the bound checker. */
`timescale 1ns/1ns
`include "dbpc_map.svh"
module dbpc_top_tb_top;
  localparam logic [7:0] RTP = 8'h03, WRC = 8'h04, WL = 8'h02, RAS = 8'h14, PB = 8'h03, RPA = 8'h05;
  localparam logic [4:0] C_ACT = `DBPC_CODE_ACT, C_PRE = `DBPC_CODE_PRE, C_RD = `DBPC_CODE_RD;
  logic       clk = 1'b0;
  logic       srst = 1'b1;
  logic       burst_32 = 1'b0;
  logic       cs;
  logic [5:0] ca;
  logic [7:0] bank_open, bank_closing, close_event;
  int         err_total = 0;
  int         comparisons = 0;
  // Short counts keep the run brief; expectations use the same values
  always #5 clk = ~clk;
  dbpc_ctl_model i_ctl (.clk(clk), .cs(cs), .ca(ca));
  dbpc_top #(.RTP_CYC(RTP), .WR_CYC(WRC), .WL_CYC(WL), .RAS_CYC(RAS), .RPPB_CYC(PB),
    .RPAB_CYC(RPA)) i_dut (.clk(clk), .srst(srst), .cs(cs), .ca(ca), .burst_32(burst_32),
    .bank_open(bank_open), .bank_closing(bank_closing), .close_event(close_event));
  task automatic finish_test();
    $display("comparisons %0d err_total %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : finish_test
  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic chk_rng(input string nm, input int lo, input int hi, input int got);
    comparisons++;
    if (got < lo || got > hi) begin
      err_total++;
      $display("mismatch %s expected %0d..%0d seen %0d", nm, lo, hi, got);
    end
  endtask : chk_rng
  // One cycle; a wait that runs long ends the run as a failure
  task automatic tick(inout int n);
    @(posedge clk);
    #1 n++;
    if (n > 300) begin
      err_total++;
      finish_test();
    end
  endtask : tick
  task automatic wait_ev(input int b, output int n);
    n = 0;
    while (close_event[b] !== 1'b1) tick(n);
  endtask : wait_ev
  task automatic close_len(output int n);
    n = 0;
    tick(n);
    while (bank_closing !== 8'h00) tick(n);
  endtask : close_len
  task automatic sc_idle();
    i_ctl.send(C_PRE, 1'b0, 3'h2);
    repeat (4) begin
      @(posedge clk);
      #1 chk("idle", 8'h00, close_event | bank_closing | bank_open);
    end
  endtask : sc_idle
  task automatic sc_single();
    int n;
    for (int b = 0; b < 8; b++) i_ctl.send(C_ACT, 1'b0, b[2:0]);
    repeat (2) @(posedge clk);
    #1 chk("open", 8'hFF, bank_open);
    for (int b = 0; b < 8; b++) begin
      i_ctl.send(C_PRE, 1'b0, b[2:0]);
      wait_ev(b, n);
      chk_rng("pre delay", 1, 1, n);
      chk("event", 8'h01 << b, close_event);
      chk("left open", 8'hFE << b, bank_open);
      close_len(n);
      chk_rng("pb time", PB, PB, n);
    end
  endtask : sc_single
  task automatic sc_all();
    int n;
    for (int b = 0; b < 8; b += 3) i_ctl.send(C_ACT, 1'b0, b[2:0]);
    repeat (3) @(posedge clk);
    #1 i_ctl.send(C_PRE, 1'b1, 3'h5);
    wait_ev(0, n);
    chk("all event", 8'h49, close_event);
    close_len(n);
    chk_rng("all time", RPA, RPA, n);
  endtask : sc_all
  // Open bank 1, wait gap cycles, then a command with auto-close
  task automatic sc_auto(input logic [4:0] code, input logic b32, input int gap, lo, hi);
    int n;
    burst_32 = b32;
    i_ctl.send(C_ACT, 1'b0, 3'h1);
    repeat (gap) @(posedge clk);
    #1 i_ctl.send(code, 1'b1, 3'h1);
    wait_ev(1, n);
    chk_rng("auto delay", lo, hi, n);
    close_len(n);
    chk_rng("auto pb time", PB, PB, n);
    chk("auto closed", 8'h00, bank_open);
  endtask : sc_auto
  task automatic sc_plain();
    int n;
    i_ctl.send(C_ACT, 1'b0, 3'h4);
    i_ctl.send(`DBPC_CODE_WR, 1'b0, 3'h4);
    i_ctl.send(C_RD, 1'b0, 3'h4);
    // The wait covers row-active, read-to-close and write recovery spacing
    repeat (RAS + 8) @(posedge clk);
    #1 chk("kept open", 8'h10, bank_open);
    i_ctl.send(C_PRE, 1'b0, 3'h4);
    wait_ev(4, n);
    chk("plain event", 8'h10, close_event);
    close_len(n);
    chk_rng("plain time", PB, PB, n);
  endtask : sc_plain
  // Plain write then read with auto-close; the gap after the activate lets row-active time run out first
  task automatic sc_wr_rd();
    int n;
    burst_32 = 1'b0;
    i_ctl.send(C_ACT, 1'b0, 3'h2);
    repeat (RAS) @(posedge clk);
    #1 i_ctl.send(`DBPC_CODE_WR, 1'b0, 3'h2);
    i_ctl.send(C_RD, 1'b1, 3'h2);
    wait_ev(2, n);
    chk_rng("wr rd delay", RTP + 1, RTP + 3, n);
    chk("wr rd event", 8'h04, close_event);
    close_len(n);
    chk_rng("wr rd time", PB, PB, n);
  endtask : sc_wr_rd
  initial begin
    repeat (12) @(posedge clk);
    #1 srst = 1'b0;
    chk("reset", 8'h00, bank_open | bank_closing | close_event);
    sc_idle();
    sc_single();
    sc_all();
    sc_plain();
    sc_wr_rd();
    sc_auto(C_RD, 1'b0, RAS, RTP + 1, RTP + 3);
    sc_auto(C_RD, 1'b1, RAS, RTP + 9, RTP + 11);
    sc_auto(`DBPC_CODE_WR, 1'b0, RAS, WL + WRC + 10, WL + WRC + 12);
    sc_auto(`DBPC_CODE_MWR, 1'b0, RAS, WL + WRC + 10, WL + WRC + 12);
    sc_auto(`DBPC_CODE_WR, 1'b1, RAS, WL + WRC + 18, WL + WRC + 20);
    sc_auto(C_RD, 1'b0, 0, RAS - 2, RAS + 2);
    finish_test();
  end
endmodule : dbpc_top_tb_top
